// *** mmupt_core.sv ***
// Mode tracking, partition decode, translation and permission checks for core fetch and data accesses.
`timescale 1ns/100ps
module mmupt_core
    import mmupt_pkg::*;
#(
    parameter bit HAS_XLATE = 1'b1,
    parameter bit HAS_REGION_PROT = 1'b0,
    parameter bit HAS_DCACHE = 1'b1,
    parameter int ENTRIES = 16,
    parameter int TAG_W = 8,
    parameter int FRAME_W = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic accValid,
    input wire mmupt_access_e accKind,
    input wire logic accIoFamily,
    input wire logic [31:0] accAddr,
    input wire logic insnPrivileged,
    input wire logic excTaken,
    input wire logic eretReturn,
    input wire logic eretToUser,
    output logic respValid,
    output logic [31:0] physAddr,
    output logic respCacheable,
    output logic respToCache,
    output logic respToBus,
    output mmupt_exc_e respExc,
    output logic userMode
);
    localparam bit USER_OK = HAS_XLATE || HAS_REGION_PROT;

    mmupt_lookup_if #(.TAG_W(TAG_W), .FRAME_W(FRAME_W)) lk ();

    logic user_q;
    logic handler_q;
    logic [TAG_W-1:0] procTag_q;
    logic [31:0] entryTag_q;
    logic [31:0] entryData_q;
    logic [$clog2(ENTRIES)-1:0] entryIndex_q;
    logic [31:0] faultAddr_q;
    mmupt_exc_e lastExc_q;
    logic wrAccess;
    logic rdAccess;
    logic entryCommit;
    logic mapped;
    logic [2:0] topBits;
    logic inIo;
    logic inKernel;
    logic inTranslated;
    logic inUserPart;
    logic permOk;
    logic [31:0] phys_d;
    logic cache_d;
    mmupt_exc_e exc_d;
    logic [31:0] rdData;
    logic regHit;
    logic wrCtrl;
    logic excEntry;
    logic needLookup;
    logic privFault;
    logic partFault;
    logic lookupMiss;
    logic permFault;
    logic grant;

    // Slave answers in the access phase with no wait states.
    assign wrAccess = psel && penable && pwrite;
    assign rdAccess = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = (wrAccess || rdAccess) && !regHit;
    // Control word writes touch the handler flag and the process tag, and the mode only from supervisor mode.
    assign wrCtrl = wrAccess && paddr == REG_CTRL;

    // Only the six word offsets answer; any other offset is refused with an error and reads zero.
    always_comb begin
        case (paddr)
            REG_CTRL: regHit = 1'b1;
            REG_ENTRY_TAG: regHit = 1'b1;
            REG_ENTRY_DATA: regHit = 1'b1;
            REG_STATUS: regHit = 1'b1;
            REG_FAULT_ADDR: regHit = 1'b1;
            REG_ENTRY_INDEX: regHit = 1'b1;
            default: regHit = 1'b0;
        endcase
    end
    // Writing the data word commits the staged tag and data into the chosen entry.
    assign entryCommit = wrAccess && paddr == REG_ENTRY_DATA && HAS_XLATE;

    // Any exception, reset and break included, lands in supervisor mode on the next edge.
    assign excEntry = excTaken || (respValid && respExc != EXC_NONE);

    // Operating mode: exception entry wins over every other update.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            user_q <= 1'b0;
        end else if (excEntry) begin
            user_q <= 1'b0;
        end else if (!USER_OK) begin
            user_q <= 1'b0;
        end else if (eretReturn) begin
            user_q <= eretToUser;
        end else if (wrCtrl && !user_q) begin
            user_q <= pwdata[CTRL_USER_BIT];
        end
    end
    assign userMode = user_q;

    // Handler flag: exception entry wins over a return or a software write in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            handler_q <= 1'b0;
        end else if (excEntry) begin
            handler_q <= 1'b1;
        end else if (eretReturn) begin
            handler_q <= 1'b0;
        end else if (wrCtrl) begin
            handler_q <= pwdata[CTRL_HANDLER_BIT];
        end
    end

    // Process tag of the running program, part of every lookup key.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            procTag_q <= '0;
        end else if (wrCtrl) begin
            procTag_q <= pwdata[CTRL_TAG_LSB +: TAG_W];
        end
    end

    // Tag half of the next entry; it waits here until the data word commits it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            entryTag_q <= '0;
        end else if (wrAccess && paddr == REG_ENTRY_TAG) begin
            entryTag_q <= pwdata;
        end
    end

    // Copy of the last data word for read-back; the entry takes the bus value directly.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            entryData_q <= '0;
        end else if (wrAccess && paddr == REG_ENTRY_DATA) begin
            entryData_q <= pwdata;
        end
    end

    // Entry index; only the bits that address an entry are kept, so larger values wrap.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            entryIndex_q <= '0;
        end else if (wrAccess && paddr == REG_ENTRY_INDEX) begin
            entryIndex_q <= pwdata[$clog2(ENTRIES)-1:0];
        end
    end

    mmupt_entry_store #(.ENTRIES(ENTRIES), .TAG_W(TAG_W), .FRAME_W(FRAME_W)) u_store (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(entryCommit),
        .wrIndex(entryIndex_q),
        .wrTag(entryTag_q),
        .wrData(pwdata),
        .lk(lk)
    );

    // Split the virtual address into page number and offset for the lookup.
    assign lk.pageNum = accAddr[ADDR_W-1:PAGE_NUM_LSB];
    assign lk.procTag = procTag_q;

    // Partition decode on the top address bits.
    // Top eighth is the peripheral window, the next eighth the kernel window; both bypass.
    // The rest of the upper half is translated for the supervisor only, the lower half for all.
    assign topBits = accAddr[31:29];
    // Without the translation unit nothing is decoded and bit 31 keeps its legacy role.
    assign mapped = HAS_XLATE;
    assign inIo = mapped && topBits == PART_IO;
    assign inKernel = mapped && topBits == PART_KERNEL;
    assign inTranslated = mapped && accAddr[31] && !inIo && !inKernel;
    assign inUserPart = mapped && !accAddr[31];

    // Permission per access kind against the matching entry.
    always_comb begin
        case (accKind)
            ACC_FETCH: permOk = lk.permExec;
            ACC_LOAD: permOk = lk.permRead;
            ACC_STORE: permOk = lk.permWrite;
            default: permOk = 1'b0;
        endcase
    end

    // Privileged instructions are refused in user mode.
    assign privFault = user_q && insnPrivileged;
    // Supervisor-only partitions refuse every user access before any lookup.
    assign partFault = user_q && (inIo || inKernel || inTranslated);
    // Only the two translated partitions consult the entries.
    assign needLookup = inTranslated || inUserPart;
    assign lookupMiss = needLookup && !lk.hit;
    assign permFault = needLookup && lk.hit && !permOk;

    // Exception priority: privilege, partition, miss, permission. A blocked access is never
    // performed, so the core can refill the entry and run the instruction again.
    always_comb begin
        exc_d = EXC_NONE;
        if (privFault) begin
            exc_d = EXC_ILLEGAL_INSN;
        end else if (partFault) begin
            exc_d = EXC_SUPERVISOR_ONLY;
        end else if (lookupMiss) begin
            exc_d = handler_q ? EXC_DOUBLE_MISS : EXC_FAST_MISS;
        end else if (permFault) begin
            exc_d = EXC_PERMISSION;
        end
    end

    // Physical address and default cacheability.
    always_comb begin
        phys_d = accAddr;
        cache_d = 1'b1;
        if (inIo || inKernel) begin
            phys_d = {3'h0, accAddr[BYPASS_ADDR_W-1:0]};
            cache_d = inKernel;
        end else if (inTranslated || inUserPart) begin
            phys_d = 32'(({lk.frameNum, accAddr[PAGE_OFFSET_W-1:0]}));
            cache_d = lk.cacheable;
        end else if (!mapped) begin
            cache_d = !accAddr[31];
        end
        if (accIoFamily && accKind != ACC_FETCH) begin
            cache_d = 1'b0;
        end
    end

    // An access is performed only when no exception blocks it.
    assign grant = accValid && exc_d == EXC_NONE;

    // Response handshake: valid and exception code follow the request by one cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            respValid <= 1'b0;
            respExc <= EXC_NONE;
        end else begin
            respValid <= accValid;
            respExc <= accValid ? exc_d : EXC_NONE;
        end
    end

    // Physical address; a blocked access shows zero so no stale address can be used.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            physAddr <= '0;
        end else begin
            physAddr <= grant ? phys_d : '0;
        end
    end

    // Routing: uncacheable data goes straight to the system bus; the cache sees only
    // cacheable data, and only when one is fitted.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            respCacheable <= 1'b0;
            respToCache <= 1'b0;
            respToBus <= 1'b0;
        end else begin
            respCacheable <= grant && cache_d;
            respToCache <= grant && cache_d && HAS_DCACHE;
            respToBus <= grant && !(cache_d && HAS_DCACHE);
        end
    end

    // Fault address keeps the virtual address that software must refill.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faultAddr_q <= '0;
        end else if (accValid && exc_d != EXC_NONE) begin
            faultAddr_q <= accAddr;
        end
    end

    // Cause of the last blocked access, read back through the status word.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lastExc_q <= EXC_NONE;
        end else if (accValid && exc_d != EXC_NONE) begin
            lastExc_q <= exc_d;
        end
    end

    // Read multiplexer; unmapped offsets read zero.
    always_comb begin
        case (paddr)
            REG_CTRL: rdData = 32'({procTag_q, 6'h00, handler_q, user_q});
            REG_ENTRY_TAG: rdData = entryTag_q;
            REG_ENTRY_DATA: rdData = entryData_q;
            REG_STATUS: rdData = {29'h0, lastExc_q};
            REG_FAULT_ADDR: rdData = faultAddr_q;
            REG_ENTRY_INDEX: rdData = 32'(entryIndex_q);
            default: rdData = '0;
        endcase
    end

    // Read data is registered so it comes from a flip-flop.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdData;
        end
    end
endmodule : mmupt_core

// *** mmupt_core_model.sv ***
// Model of the core pipeline that issues accesses and mode events.
`timescale 1ns/100ps
module mmupt_core_model
    import mmupt_pkg::*;
(
    input wire logic clk,
    output logic accValid,
    output mmupt_access_e accKind,
    output logic accIoFamily,
    output logic [31:0] accAddr,
    output logic insnPrivileged,
    output logic excTaken,
    output logic eretReturn,
    output logic eretToUser
);
    // Idle values at time zero.
    initial begin
        {accValid, accIoFamily, insnPrivileged, excTaken, eretReturn, eretToUser} = 6'h0;
        accKind = ACC_FETCH;
        accAddr = 32'h0;
    end

    // One access; the address is inverted when idle so a stale value is never trusted.
    task automatic access(input mmupt_access_e k, input logic io, input logic pr, input logic [31:0] a);
        @(posedge clk);
        accValid <= 1'b1;
        accKind <= k;
        accIoFamily <= io;
        insnPrivileged <= pr;
        accAddr <= a;
        @(posedge clk);
        accValid <= 1'b0;
        accAddr <= ~a;
        #1;
    endtask : access

    // One-cycle exception or return pulse.
    task automatic pulse(input logic ex, input logic ret, input logic toUser);
        @(posedge clk);
        excTaken <= ex;
        eretReturn <= ret;
        eretToUser <= toUser;
        @(posedge clk);
        excTaken <= 1'b0;
        eretReturn <= 1'b0;
    endtask : pulse
endmodule : mmupt_core_model

// *** mmupt_core_sva.sv ***
// Checker for the access and mode ports of the translation block.
`timescale 1ns/100ps
module mmupt_core_sva
    import mmupt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic accValid,
    input wire mmupt_access_e accKind,
    input wire logic accIoFamily,
    input wire logic [31:0] accAddr,
    input wire logic insnPrivileged,
    input wire logic excTaken,
    input wire logic eretReturn,
    input wire logic eretToUser,
    input wire logic respValid,
    input wire logic [31:0] physAddr,
    input wire logic respCacheable,
    input wire logic respToCache,
    input wire logic respToBus,
    input wire mmupt_exc_e respExc,
    input wire logic userMode
);
    // One clock domain, so clocking and reset are declared once.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_resp; respValid == $past(accValid); endproperty
    property p_byp; accValid && accAddr[31:30] == 2'h3 && !userMode
        |=> respExc == EXC_NONE && physAddr == {3'h0, $past(accAddr[28:0])}; endproperty
    property p_io; accValid && accAddr[31:29] == PART_IO |=> !respCacheable && !respToCache; endproperty
    property p_kern; accValid && accAddr[31:29] == PART_KERNEL && !accIoFamily && !userMode
        |=> respCacheable; endproperty
    property p_iofam; accValid && accIoFamily && accKind != ACC_FETCH |=> !respCacheable; endproperty
    property p_deny; accValid && userMode && accAddr[31] |=> respExc != EXC_NONE; endproperty
    property p_off; accValid |=> respExc != EXC_NONE || physAddr[11:0] == $past(accAddr[11:0]); endproperty
    property p_route; respValid && respExc == EXC_NONE
        |-> respToCache == respCacheable && respToBus == !respCacheable; endproperty
    property p_super; excTaken || (respValid && respExc != EXC_NONE) |=> !userMode; endproperty
    property p_priv; accValid && userMode && insnPrivileged |=> respExc != EXC_NONE; endproperty
    a_resp: assert property (p_resp) else $error("response valid mistimed");
    a_byp: assert property (p_byp) else $error("bypass address wrong");
    a_io: assert property (p_io) else $error("peripheral access cached");
    a_kern: assert property (p_kern) else $error("kernel access uncached");
    a_iofam: assert property (p_iofam) else $error("io family access cached");
    a_deny: assert property (p_deny) else $error("user reached upper half");
    a_off: assert property (p_off) else $error("page offset altered");
    a_route: assert property (p_route) else $error("cache or bus route wrong");
    a_super: assert property (p_super) else $error("exception left user mode");
    a_priv: assert property (p_priv) else $error("privileged insn allowed");
    c_user: cover property (accValid && userMode);
    c_dbl: cover property (respValid && respExc == EXC_DOUBLE_MISS);
    c_eret: cover property (eretReturn && eretToUser);
endmodule : mmupt_core_sva

bind mmupt_core mmupt_core_sva mmupt_core_sva_i (.clk(clk), .rst_n(rst_n), .accValid(accValid),
    .accKind(accKind), .accIoFamily(accIoFamily), .accAddr(accAddr), .insnPrivileged(insnPrivileged),
    .excTaken(excTaken), .eretReturn(eretReturn), .eretToUser(eretToUser), .respValid(respValid),
    .physAddr(physAddr), .respCacheable(respCacheable), .respToCache(respToCache),
    .respToBus(respToBus), .respExc(respExc), .userMode(userMode));

// *** mmupt_entry_store.sv ***
// Software-filled lookup entries held in flip-flops and matched in parallel.
`timescale 1ns/100ps
module mmupt_entry_store
    import mmupt_pkg::*;
#(
    parameter int ENTRIES = 16,
    parameter int TAG_W = 8,
    parameter int FRAME_W = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire logic [$clog2(ENTRIES)-1:0] wrIndex,
    input wire logic [31:0] wrTag,
    input wire logic [31:0] wrData,
    mmupt_lookup_if.store lk
);
    logic valid_q [ENTRIES];
    logic [ENTRIES-1:0] matchVec;
    logic [PAGE_NUM_W-1:0] pageNum_q [ENTRIES];
    logic [TAG_W-1:0] procTag_q [ENTRIES];
    logic global_q [ENTRIES];
    logic [FRAME_W+3:0] data_q [ENTRIES];

    // Entries change only by software writes; nothing here ever reads a table in memory.
    genvar gi;
    for (gi = 0; gi < ENTRIES; gi++) begin : g_entry
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                valid_q[gi] <= 1'b0;
                pageNum_q[gi] <= '0;
                procTag_q[gi] <= '0;
                global_q[gi] <= 1'b0;
                data_q[gi] <= '0;
            end else if (wrEn && wrIndex == gi) begin
                valid_q[gi] <= 1'b1;
                pageNum_q[gi] <= wrTag[PAGE_NUM_W-1:0];
                procTag_q[gi] <= wrTag[PAGE_NUM_W+TAG_W-1:PAGE_NUM_W];
                global_q[gi] <= wrTag[TAG_GLOBAL_BIT];
                data_q[gi] <= {wrData[DATA_EXEC_BIT:DATA_CACHE_BIT], wrData[FRAME_W-1:0]};
            end
        end
        // Page must match and either the entry is global or its tag is current.
        assign matchVec[gi] = valid_q[gi] && pageNum_q[gi] == lk.pageNum &&
                              (global_q[gi] || procTag_q[gi] == lk.procTag);
    end

    // Software keeps entries unique, so an OR of the matching entries gives the result.
    always_comb begin
        logic [FRAME_W+3:0] sel;
        sel = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (matchVec[i]) begin
                sel = sel | data_q[i];
            end
        end
        lk.hit = |matchVec;
        lk.frameNum = sel[FRAME_W-1:0];
        lk.cacheable = sel[FRAME_W];
        lk.permRead = sel[FRAME_W+1];
        lk.permWrite = sel[FRAME_W+2];
        lk.permExec = sel[FRAME_W+3];
    end
endmodule : mmupt_entry_store

// *** mmupt_lookup_if.sv ***
// Interface carrying one lookup request and its result between the main block and the entry store.
`timescale 1ns/100ps
interface mmupt_lookup_if #(parameter int TAG_W = 8, parameter int FRAME_W = 20);
    logic [19:0] pageNum;
    logic [TAG_W-1:0] procTag;
    logic hit;
    logic [FRAME_W-1:0] frameNum;
    logic permRead;
    logic permWrite;
    logic permExec;
    logic cacheable;
    modport requester (output pageNum, output procTag, input hit, input frameNum, input permRead,
                       input permWrite, input permExec, input cacheable);
    modport store (input pageNum, input procTag, output hit, output frameNum, output permRead,
                   output permWrite, output permExec, output cacheable);
endinterface : mmupt_lookup_if

// *** mmupt_pkg.sv ***
// Package with partition bounds, field layouts, register offsets and enumerations for the translation block.
package mmupt_pkg;
    localparam int ADDR_W = 32;
    localparam int PAGE_OFFSET_W = 12;
    localparam int PAGE_NUM_W = 20;
    localparam int PAGE_NUM_LSB = 12;
    localparam int BYPASS_ADDR_W = 29;
    localparam logic [2:0] PART_IO = 3'h7;
    localparam logic [2:0] PART_KERNEL = 3'h6;
    localparam logic [31:0] REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] REG_ENTRY_TAG = 32'h0000_0004;
    localparam logic [31:0] REG_ENTRY_DATA = 32'h0000_0008;
    localparam logic [31:0] REG_STATUS = 32'h0000_000c;
    localparam logic [31:0] REG_FAULT_ADDR = 32'h0000_0010;
    localparam logic [31:0] REG_ENTRY_INDEX = 32'h0000_0014;
    localparam int CTRL_USER_BIT = 0;
    localparam int CTRL_HANDLER_BIT = 1;
    localparam int CTRL_TAG_LSB = 8;
    localparam int TAG_GLOBAL_BIT = 31;
    localparam int DATA_CACHE_BIT = 20;
    localparam int DATA_READ_BIT = 21;
    localparam int DATA_WRITE_BIT = 22;
    localparam int DATA_EXEC_BIT = 23;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {ACC_FETCH, ACC_LOAD, ACC_STORE} mmupt_access_e;
    typedef enum logic [2:0] {EXC_NONE, EXC_FAST_MISS, EXC_DOUBLE_MISS, EXC_PERMISSION, EXC_SUPERVISOR_ONLY,
                              EXC_ILLEGAL_INSN} mmupt_exc_e;
endpackage : mmupt_pkg

// *** tb_top.sv ***
// Self-checking bench for the translation block.
`timescale 1ns/100ps
module tb_top
    import mmupt_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, physAddr, a, rd;
    logic pready, pslverr, accValid, accIoFamily, insnPrivileged, excTaken, eretReturn, eretToUser;
    logic respValid, respCacheable, respToCache, respToBus, userMode, err;
    logic [11:0] off;
    logic [31:0] accAddr;
    mmupt_access_e accKind;
    mmupt_exc_e respExc;
    int nFail = 0, checksDone = 0;

    // Free-running 50 MHz clock.
    always #10 clk = ~clk;

    mmupt_core mmupt_core_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .accValid(accValid), .accKind(accKind), .accIoFamily(accIoFamily), .accAddr(accAddr),
        .insnPrivileged(insnPrivileged), .excTaken(excTaken), .eretReturn(eretReturn),
        .eretToUser(eretToUser), .respValid(respValid), .physAddr(physAddr), .respCacheable(respCacheable),
        .respToCache(respToCache), .respToBus(respToBus), .respExc(respExc), .userMode(userMode));
    mmupt_core_model mmupt_core_model_i (.clk(clk), .accValid(accValid), .accKind(accKind),
        .accIoFamily(accIoFamily), .accAddr(accAddr), .insnPrivileged(insnPrivileged),
        .excTaken(excTaken), .eretReturn(eretReturn), .eretToUser(eretToUser));

    // Bypass clears the top three bits.
    function automatic logic [31:0] bypass(input logic [31:0] v);
        return {3'h0, v[28:0]};
    endfunction : bypass

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nFail++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : check

    // One APB transfer; the request is held until pready is seen at an edge, for at most 16 edges.
    task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            nFail++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [31:0] ad, input logic [31:0] exp, input logic experr);
        apb(1'b0, ad, 32'h0);
        check("read data", rd, exp);
        check("slave error", err, experr);
    endtask : rdchk

    task automatic entry(input logic [31:0] idx, input logic [31:0] t, input logic [31:0] d);
        apb(1'b1, REG_ENTRY_INDEX, idx);
        apb(1'b1, REG_ENTRY_TAG, t);
        apb(1'b1, REG_ENTRY_DATA, d);
    endtask : entry

    // Valid and exception code are checked first; cacheability only matters for completed accesses.
    task automatic acc(input mmupt_access_e k, input logic io, input logic pr, input logic [31:0] v,
                       input logic [31:0] ep, input mmupt_exc_e ee, input logic ec);
        mmupt_core_model_i.access(k, io, pr, v);
        check("valid", respValid, 32'h1);
        check("exception", respExc, ee);
        check("phys", physAddr, ep);
        if (ee == EXC_NONE) begin
            check("cacheable", respCacheable, ec);
            check("to bus", respToBus, !ec);
        end
    endtask : acc

    task automatic mode(input logic exp);
        repeat (2) @(posedge clk);
        #1;
        check("user mode", userMode, exp);
    endtask : mode

    // Main sequence: reset, random bypass traffic, lookups, faults and mode changes.
    initial begin
        void'($urandom(32'h6355));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        mode(1'b0);
        rdchk(REG_CTRL, CTRL_RESET, 1'b0);
        rdchk(32'h40, 32'h0, 1'b1);
        apb(1'b1, REG_CTRL, 32'h500);
        entry(0, 32'h0050_0012, 32'h00ba_bcde);
        for (int i = 0; i < 8; i++) begin
            a = {3'h6, 29'($urandom)};
            acc(ACC_LOAD, 1'b0, 1'b1, a, bypass(a), EXC_NONE, 1'b1);
            a = {3'h7, 29'($urandom)};
            acc(ACC_STORE, 1'b0, 1'b0, a, bypass(a), EXC_NONE, 1'b0);
            a = {3'h6, 29'($urandom)};
            acc(ACC_STORE, 1'b1, 1'b0, a, bypass(a), EXC_NONE, 1'b0);
            off = 12'($urandom);
            acc(ACC_FETCH, 1'b0, 1'b0, {20'h12, off}, {20'habcde, off}, EXC_NONE, 1'b1);
        end
        acc(ACC_LOAD, 1'b0, 1'b0, 32'h0001_2344, 32'habcd_e344, EXC_NONE, 1'b1);
        acc(ACC_STORE, 1'b0, 1'b0, 32'h0001_2344, 32'h0, EXC_PERMISSION, 1'b0);
        acc(ACC_LOAD, 1'b0, 1'b0, 32'h0001_3000, 32'h0, EXC_DOUBLE_MISS, 1'b0);
        rdchk(REG_STATUS, 32'(EXC_DOUBLE_MISS), 1'b0);
        rdchk(REG_FAULT_ADDR, 32'h0001_3000, 1'b0);
        mmupt_core_model_i.pulse(1'b0, 1'b1, 1'b0);
        acc(ACC_LOAD, 1'b0, 1'b0, 32'h0001_3000, 32'h0, EXC_FAST_MISS, 1'b0);
        mmupt_core_model_i.pulse(1'b0, 1'b1, 1'b0);
        apb(1'b1, REG_CTRL, 32'h600);
        acc(ACC_LOAD, 1'b0, 1'b0, 32'h0001_2344, 32'h0, EXC_FAST_MISS, 1'b0);
        mmupt_core_model_i.pulse(1'b0, 1'b1, 1'b0);
        apb(1'b1, REG_CTRL, 32'h602);
        acc(ACC_LOAD, 1'b0, 1'b0, 32'h0001_2344, 32'h0, EXC_DOUBLE_MISS, 1'b0);
        mmupt_core_model_i.pulse(1'b0, 1'b1, 1'b0);
        entry(1, 32'h8008_0001, 32'h00ef_ff00);
        rdchk(REG_ENTRY_TAG, 32'h8008_0001, 1'b0);
        acc(ACC_LOAD, 1'b0, 1'b0, 32'h8000_1abc, 32'hfff0_0abc, EXC_NONE, 1'b0);
        apb(1'b1, REG_CTRL, 32'h500);
        mmupt_core_model_i.pulse(1'b0, 1'b1, 1'b1);
        mode(1'b1);
        acc(ACC_LOAD, 1'b0, 1'b0, 32'h0001_2008, 32'habcd_e008, EXC_NONE, 1'b1);
        acc(ACC_LOAD, 1'b0, 1'b0, 32'hc000_0010, 32'h0, EXC_SUPERVISOR_ONLY, 1'b0);
        mode(1'b0);
        mmupt_core_model_i.pulse(1'b0, 1'b1, 1'b1);
        acc(ACC_FETCH, 1'b0, 1'b1, 32'h0001_2008, 32'h0, EXC_ILLEGAL_INSN, 1'b0);
        mmupt_core_model_i.pulse(1'b0, 1'b1, 1'b1);
        mmupt_core_model_i.pulse(1'b1, 1'b0, 1'b0);
        mode(1'b0);
        // A reset in mid-run from user mode must come back in supervisor mode with no valid entries.
        mmupt_core_model_i.pulse(1'b0, 1'b1, 1'b1);
        mode(1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        check("user mode in reset", userMode, 32'h0);
        rst_n <= 1'b1;
        acc(ACC_LOAD, 1'b0, 1'b0, 32'h0001_2344, 32'h0, EXC_FAST_MISS, 1'b0);
        print_verdict();
    end
endmodule : tb_top
